// *** epc_ctrl.sv ***
// Purpose: extended control of a bidirectional parallel port
// Assumes: cable handshake engine and DMA pacing sit outside this block
// Notes:   registers on a classic Wishbone slave, byte address = index * 4
//
// Overview of operation
// - three-bit mode field selects operation
// - fault falling edge pulses interrupt when enabled in ECP mode
// - enabling in ECP mode with fault already low interrupts
// - DMA enable permits requests, clearing stops them
// - service flag set blocks DMA, service interrupts
// - hardware sets service flag, software clears
// - terminal count sets service flag under DMA
// - forward: free space threshold sets flag
// - reverse: fill threshold sets flag
// - full and empty read-only status bits
// - standard mode resets queue, open-collector controls
// - bidirectional mode tri-states data, reads pins
// - queue mode sends bytes with compatible handshake
// - ECP mode merges commands and data, packs input
// - EPP only when option set; 101 reserved
// - test mode: host access, never transmitted
// - configuration mode shows capability registers
// - entering queue or ECP mode starts transfer
// - mode changes only via 000/001; direction only in 001
// - leaving extended modes restores controls cleanly
// - commands forward only; reverse fills queue
// - modes 000, 010 always drive outward
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/100ps
module epc_ctrl #(
	parameter int ADR_W = 13,
	parameter int DEPTH = epc_pkg::FIFO_DEPTH,
	parameter int THR_W = epc_pkg::THR_BITS
) (
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	input  wire logic                 wb_cyc,
	input  wire logic                 wb_stb,
	input  wire logic                 wb_we,
	input  wire logic [ADR_W-1:0]     wb_adr,
	input  wire logic [3:0]           wb_sel,
	input  wire logic [31:0]          wb_wdat,
	output logic      [31:0]          wb_rdat,
	output logic                      wb_ack,
	input  wire logic [THR_W-1:0]     tx_free_level,
	input  wire logic [THR_W-1:0]     rx_fill_level,
	input  wire logic                 chip_config_four,
	input  wire logic                 dma_tc,
	input  wire logic                 dma_ack,
	input  wire logic [7:0]           dma_wdat,
	output logic                      dma_req,
	output logic      [7:0]           dma_rdat,
	output logic                      tx_valid,
	input  wire logic                 tx_ready,
	output epc_pkg::epc_qent_type     tx_ent,
	input  wire logic                 rx_valid,
	output logic                      rx_ready,
	input  wire logic [7:0]           rx_data,
	input  wire epc_pkg::epc_ctl_type eng_ctl,
	input  wire logic                 peripheral_error_in_n,
	input  wire logic [7:0]           pd_i,
	output logic      [7:0]           pd_o,
	output logic                      pd_oe_n,
	output epc_pkg::epc_ctl_type      ctl_o,
	output epc_pkg::epc_ctl_type      ctl_oe_n,
	output epc_pkg::epc_mode_type     mode,
	output logic                      dir_in,
	output logic                      epp_active,
	output logic                      irq_pulse
);
	localparam int CW = $clog2(DEPTH+1);

	logic [1:0]            rst_sync_q;
	logic                  rst_n;
	logic                  ack_q;
	logic [7:0]            rdat_q;
	logic [7:0]            rdat_d;
	epc_pkg::epc_mode_type mode_q;
	epc_pkg::epc_mode_type new_mode;
	logic                  fault_en_n_q;
	logic                  dma_en_q;
	logic                  svc_q;
	logic [5:0]            dctl_q;
	logic [7:0]            data_q;
	logic                  flt_prev_q;
	logic                  irq_q;
	epc_pkg::epc_ctl_type  ctl_q;
	epc_pkg::epc_ctl_type  ctl_oe_q;
	epc_pkg::epc_ctl_type  ctl_d;
	logic                  req;
	logic [10:0]           idx;
	logic                  wr_fire;
	logic                  rd_fire;
	logic [7:0]            wd;
	logic                  mode_ok;
	logic                  dir_eff;
	logic                  fifo_mode;
	logic                  auto_tx;
	logic                  rx_mode;
	logic                  fault_fire;
	logic                  svc_cond;
	logic                  svc_hit;
	logic [CW-1:0]         tx_thr;
	logic [CW-1:0]         rx_thr;
	logic [CW-1:0]         free;
	logic                  host_push;
	logic                  cmd_push;
	logic                  dma_push;
	logic                  rx_push;
	logic                  q_push;
	epc_pkg::epc_qent_type q_in;
	logic                  q_pop;
	logic                  q_clr;
	epc_pkg::epc_qent_type q_head;
	logic                  q_full;
	logic                  q_empty;
	logic [CW-1:0]         q_count;

	// Threshold range must fit the queue
	if ((1 << THR_W) > DEPTH || ADR_W < 13) begin : g_chk
		$error("epc_ctrl threshold width or address width unsupported");
	end

	// Reset release through two flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_q <= 2'b00;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Bus decode; write and pop act on the acknowledged edge
	assign req     = wb_cyc & wb_stb;
	assign idx     = wb_adr[12:2];
	assign wd      = wb_wdat[7:0];
	assign wr_fire = req & wb_we & ack_q & wb_sel[0];
	assign rd_fire = req & ~wb_we & ack_q;

	// Mode helpers
	// forced outward
	assign dir_eff   = dctl_q[epc_pkg::DC_DIR] & ~(mode_q == epc_pkg::EPC_M_SPP
		| mode_q == epc_pkg::EPC_M_PFIFO);
	assign fifo_mode = (mode_q == epc_pkg::EPC_M_PFIFO)
		| (mode_q == epc_pkg::EPC_M_ECP) | (mode_q == epc_pkg::EPC_M_TEST);
	assign auto_tx   = ((mode_q == epc_pkg::EPC_M_PFIFO)
		| (mode_q == epc_pkg::EPC_M_ECP)) & ~dir_eff;
	assign rx_mode   = (mode_q == epc_pkg::EPC_M_ECP) & dir_eff;

	assign new_mode = epc_pkg::epc_mode_type'(wd[7:5]);
	assign mode_ok  = (mode_q == epc_pkg::EPC_M_SPP)
		| (mode_q == epc_pkg::EPC_M_BIDIR)
		| (new_mode == epc_pkg::EPC_M_SPP)
		| (new_mode == epc_pkg::EPC_M_BIDIR);

	// Wishbone acknowledge, one cycle per request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end
	assign wb_ack  = ack_q;
	assign wb_rdat = {24'h000000, rdat_q};

	// Read data selection
	always_comb begin
		rdat_d = 8'h00;
		case (idx)
			epc_pkg::IDX_DATA: begin
				rdat_d = (mode_q == epc_pkg::EPC_M_BIDIR) ? pd_i : data_q;
			end
			epc_pkg::IDX_DCTL: begin
				rdat_d = {2'b00, dctl_q};
			end
			// capability a in place of queue
			epc_pkg::IDX_FIFO: begin
				if (mode_q == epc_pkg::EPC_M_CFG) begin
					rdat_d = epc_pkg::CAP_A_VAL;
				end else if (fifo_mode) begin
					rdat_d = q_head.data;
				end
			end
			epc_pkg::IDX_CAPB: begin
				if (mode_q == epc_pkg::EPC_M_CFG) begin
					rdat_d[epc_pkg::CB_IRQ] = irq_q;
				end
			end
			epc_pkg::IDX_XCTL: begin
				rdat_d = {mode_q, fault_en_n_q, dma_en_q, svc_q,
					q_full, q_empty};
			end
			default: begin
				rdat_d = 8'h00;
			end
		endcase
	end

	// Read data latched as the answer is given
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdat_q <= 8'h00;
		end else if (req && !ack_q) begin
			rdat_q <= rdat_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= epc_pkg::MODE_RST;
		end else if (wr_fire && idx == epc_pkg::IDX_XCTL && mode_ok) begin
			mode_q <= new_mode;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_en_n_q <= epc_pkg::FLT_RST;
			dma_en_q     <= epc_pkg::DMA_RST;
		end else if (wr_fire && idx == epc_pkg::IDX_XCTL) begin
			fault_en_n_q <= wd[epc_pkg::XC_FLT];
			dma_en_q     <= wd[epc_pkg::XC_DMA];
		end
	end

	// Service conditions
	assign tx_thr = CW'(tx_free_level) + CW'(1);
	assign rx_thr = CW'(rx_fill_level) + CW'(1);
	assign free   = CW'(DEPTH) - q_count;
	always_comb begin
		svc_hit = 1'b0;
		if (dma_en_q) begin
			svc_hit = dma_tc;
		end else if (dir_eff) begin
			svc_hit = (q_count >= rx_thr);
		end else begin
			svc_hit = (free >= tx_thr);
		end
	end
	assign svc_cond = ~svc_q & fifo_mode & svc_hit;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			svc_q <= epc_pkg::SVC_RST;
		end else if (svc_cond) begin
			svc_q <= 1'b1;
		end else if (wr_fire && idx == epc_pkg::IDX_XCTL) begin
			svc_q <= wd[epc_pkg::XC_SVC];
		end
	end

	// Previous fault level for edge detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flt_prev_q <= 1'b1;
		end else begin
			flt_prev_q <= peripheral_error_in_n;
		end
	end

	assign fault_fire = (mode_q == epc_pkg::EPC_M_ECP) & (
		(~fault_en_n_q & flt_prev_q & ~peripheral_error_in_n)
		| (wr_fire & (idx == epc_pkg::IDX_XCTL) & fault_en_n_q
		& ~wd[epc_pkg::XC_FLT] & ~peripheral_error_in_n));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= svc_cond | fault_fire;
		end
	end
	assign irq_pulse = irq_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dctl_q <= epc_pkg::DCTL_RST;
		end else if (wr_fire && idx == epc_pkg::IDX_DCTL) begin
			dctl_q[4:0] <= wd[4:0];
			if (mode_q == epc_pkg::EPC_M_BIDIR) begin
				dctl_q[epc_pkg::DC_DIR] <= wd[epc_pkg::DC_DIR];
			end
		end
	end

	// Data latch in programmed modes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_q <= epc_pkg::DATA_RST;
		end else if (wr_fire && idx == epc_pkg::IDX_DATA
			&& (mode_q == epc_pkg::EPC_M_SPP
			|| mode_q == epc_pkg::EPC_M_BIDIR)) begin
			data_q <= wd;
		end
	end

	// host writes queue in queue modes
	assign host_push = wr_fire & (idx == epc_pkg::IDX_FIFO) & fifo_mode
		& ~rx_mode;
	assign cmd_push  = wr_fire & (idx == epc_pkg::IDX_DATA)
		& (mode_q == epc_pkg::EPC_M_ECP) & ~dir_eff;
	assign dma_push  = dma_ack & fifo_mode & ~dir_eff;
	assign rx_ready  = rx_mode & ~q_full;
	assign rx_push   = rx_valid & rx_ready;
	assign q_push    = host_push | cmd_push | dma_push | rx_push;

	// Entry selection, host first
	always_comb begin
		q_in.cmd  = cmd_push;
		q_in.data = rx_data;
		if (host_push || cmd_push) begin
			q_in.data = wd;
		end else if (dma_push) begin
			q_in.data = dma_wdat;
		end
	end

	assign tx_valid = auto_tx & ~q_empty;
	assign tx_ent   = q_head;
	assign q_pop    = (rd_fire & (idx == epc_pkg::IDX_FIFO) & fifo_mode)
		| (dma_ack & fifo_mode & dir_eff) | (tx_valid & tx_ready);
	// queue held empty in mode 000
	assign q_clr    = (mode_q == epc_pkg::EPC_M_SPP);

	assign dma_req  = dma_en_q & ~svc_q & fifo_mode
		& (dir_eff ? ~q_empty : ~q_full);
	assign dma_rdat = q_head.data;

	assign epp_active = (mode_q == epc_pkg::EPC_M_EPP) & chip_config_four;
	assign mode       = mode_q;
	assign dir_in     = dir_eff;
	assign pd_o       = data_q;
	assign pd_oe_n    = dir_eff;

	// Control line source per mode
	always_comb begin
		ctl_d.strobe_out_n      = ~dctl_q[epc_pkg::DC_STROBE];
		ctl_d.auto_feed_out_n   = ~dctl_q[epc_pkg::DC_AUTOFD];
		ctl_d.init_out_n        = dctl_q[epc_pkg::DC_INIT];
		ctl_d.host_select_out_n = ~dctl_q[epc_pkg::DC_SELIN];
		if (mode_q == epc_pkg::EPC_M_PFIFO || mode_q == epc_pkg::EPC_M_ECP) begin
			ctl_d = eng_ctl;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_q    <= '1;
			ctl_oe_q <= '1;
		end else begin
			ctl_q    <= ctl_d;
			ctl_oe_q <= (mode_q == epc_pkg::EPC_M_SPP) ? ctl_d : '0;
		end
	end
	assign ctl_o    = ctl_q;
	assign ctl_oe_n = ctl_oe_q;

	// Queue storage
	epc_fifo #(
		.WIDTH ($bits(epc_pkg::epc_qent_type)),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.clr       (q_clr),
		.push      (q_push),
		.push_data (q_in),
		.pop       (q_pop),
		.head      (q_head),
		.full      (q_full),
		.empty     (q_empty),
		.count     (q_count)
	);

	// Checks
	sequence s_xctl_wr;
		wr_fire && idx == epc_pkg::IDX_XCTL;
	endsequence
	sequence s_svc_open;
		!svc_q && fifo_mode;
	endsequence

	property p_mode_lock;
		@(posedge clk) disable iff (!rst_n)
		s_xctl_wr ##0 !mode_ok |=> mode_q == $past(mode_q);
	endproperty
	a_mode_lock: assert property (p_mode_lock)
		else $error("illegal mode change taken");

	property p_dir_lock;
		@(posedge clk) disable iff (!rst_n)
		(mode_q != epc_pkg::EPC_M_BIDIR) |=> $stable(dctl_q[epc_pkg::DC_DIR]);
	endproperty
	a_dir_lock: assert property (p_dir_lock)
		else $error("direction changed outside mode 001");

	property p_fault_edge;
		@(posedge clk) disable iff (!rst_n)
		mode_q == epc_pkg::EPC_M_ECP && !fault_en_n_q
		&& flt_prev_q && !peripheral_error_in_n |=> irq_pulse;
	endproperty
	a_fault_edge: assert property (p_fault_edge)
		else $error("fault edge gave no interrupt");

	property p_fault_arm;
		@(posedge clk) disable iff (!rst_n)
		s_xctl_wr ##0 mode_q == epc_pkg::EPC_M_ECP && fault_en_n_q
		&& !wd[epc_pkg::XC_FLT] && !peripheral_error_in_n |=> irq_pulse;
	endproperty
	a_fault_arm: assert property (p_fault_arm)
		else $error("pending fault lost on enable");

	property p_dma_block;
		@(posedge clk) disable iff (!rst_n)
		(!dma_en_q || svc_q) |-> !dma_req;
	endproperty
	a_dma_block: assert property (p_dma_block)
		else $error("DMA request while blocked");

	property p_svc_quiet;
		@(posedge clk) disable iff (!rst_n)
		$past(svc_q) && !$past(fault_fire) |-> !irq_pulse;
	endproperty
	a_svc_quiet: assert property (p_svc_quiet)
		else $error("interrupt while service flag set");

	property p_tc_set;
		@(posedge clk) disable iff (!rst_n)
		s_svc_open ##0 dma_en_q && dma_tc |=> svc_q && irq_pulse;
	endproperty
	a_tc_set: assert property (p_tc_set)
		else $error("terminal count did not set flag");

	property p_tx_thr;
		@(posedge clk) disable iff (!rst_n)
		s_svc_open ##0 !dma_en_q && !dir_eff && free >= tx_thr
		|=> svc_q ##0 irq_pulse;
	endproperty
	a_tx_thr: assert property (p_tx_thr)
		else $error("free threshold did not set flag");

	property p_rx_thr;
		@(posedge clk) disable iff (!rst_n)
		s_svc_open ##0 !dma_en_q && dir_eff && q_count >= rx_thr
		|=> svc_q ##0 irq_pulse;
	endproperty
	a_rx_thr: assert property (p_rx_thr)
		else $error("fill threshold did not set flag");

	property p_fifo_rst;
		@(posedge clk) disable iff (!rst_n)
		mode_q == epc_pkg::EPC_M_SPP |=> q_empty && !tx_valid;
	endproperty
	a_fifo_rst: assert property (p_fifo_rst)
		else $error("queue not held empty in mode 000");

	property p_oc;
		@(posedge clk) disable iff (!rst_n)
		mode_q == epc_pkg::EPC_M_SPP |=> ctl_oe_n == ctl_o;
	endproperty
	a_oc: assert property (p_oc)
		else $error("controls not open collector in mode 000");

	property p_fwd;
		@(posedge clk) disable iff (!rst_n)
		(mode_q == epc_pkg::EPC_M_SPP || mode_q == epc_pkg::EPC_M_PFIFO)
		|-> !pd_oe_n;
	endproperty
	a_fwd: assert property (p_fwd)
		else $error("data lines released in forced outward mode");

	property p_test_hold;
		@(posedge clk) disable iff (!rst_n)
		mode_q == epc_pkg::EPC_M_TEST |-> !tx_valid;
	endproperty
	a_test_hold: assert property (p_test_hold)
		else $error("test mode offered data to the cable");

endmodule // epc_ctrl

// *** epc_fifo.sv ***
// Purpose: byte queue between host, DMA and the cable handshake engine
// Assumes: one push and one pop source per cycle
// Notes:   push when full and pop when empty are ignored
`timescale 1ns/100ps
module epc_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	input  wire logic                     clr,
	input  wire logic                     push,
	input  wire logic [WIDTH-1:0]         push_data,
	input  wire logic                     pop,
	output logic      [WIDTH-1:0]         head,
	output logic                          full,
	output logic                          empty,
	output logic      [$clog2(DEPTH+1)-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [CW-1:0]    cnt_q;
	logic             do_push;
	logic             do_pop;

	// Depth must be a power of two of at least two
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("epc_fifo depth must be a power of two");
	end

	assign do_push = push & ~full;
	assign do_pop  = pop & ~empty;
	assign full    = (cnt_q == CW'(DEPTH));
	assign empty   = (cnt_q == '0);
	assign count   = cnt_q;
	assign head    = mem_q[rd_q];

	// Storage written at the tail
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem_q[wr_q] <= push_data;
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (clr) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (do_push) begin
				wr_q <= wr_q + AW'(1);
			end
			if (do_pop) begin
				rd_q <= rd_q + AW'(1);
			end
			if (do_push && !do_pop) begin
				cnt_q <= cnt_q + CW'(1);
			end else if (do_pop && !do_push) begin
				cnt_q <= cnt_q - CW'(1);
			end
		end
	end

endmodule // epc_fifo

// *** epc_periph_model.sv ***
// Purpose: peripheral on the far side of the cable handshake engine
// Assumes: forward traffic only, no reverse bytes are offered
// Notes:   slow mode stalls every other cycle
`timescale 1ns/100ps
module epc_periph_model (
	input  wire logic                  clk,
	input  wire logic                  slow,
	input  wire logic                  tx_valid,
	input  wire epc_pkg::epc_qent_type tx_ent,
	output logic                       tx_ready,
	output logic                       rx_valid,
	output logic [7:0]                 rx_data,
	input  wire logic                  fault_req,
	output logic                       peripheral_error_in_n
);
	epc_pkg::epc_qent_type got [0:7];
	int                    n_got = 0;
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_data = 8'h00;
	end
	// Accept queue bytes, stalling in slow mode
	always @(posedge clk) begin
		if (tx_valid && tx_ready && n_got < 8) begin
			got[n_got] <= tx_ent;
			n_got <= n_got + 1;
		end
		tx_ready <= slow ? ~tx_ready : 1'b1;
		rx_valid <= 1'b0;
		rx_data <= rx_data + 8'h5b; // Idle data never holds still
	end
	// Fault line driven as the bench asks
	assign peripheral_error_in_n = ~fault_req;
endmodule // epc_periph_model

// *** epc_pkg.sv ***
// Purpose: shared constants and types of the extended port control block
// Assumes: registers are reached by word index, byte address is index * 4
// Notes:   register indices, field positions and reset values live here
package epc_pkg;

	// Register word indices
	localparam logic [10:0] IDX_DATA = 11'h000; // Data latch or command queue
	localparam logic [10:0] IDX_DCTL = 11'h002; // Port control lines
	localparam logic [10:0] IDX_FIFO = 11'h400; // Data queue or capability a
	localparam logic [10:0] IDX_CAPB = 11'h401; // Capability b
	localparam logic [10:0] IDX_XCTL = 11'h402; // Extended port control

	// Extended port control field positions
	localparam int XC_MODE_LSB = 5;
	localparam int XC_FLT      = 4;
	localparam int XC_DMA      = 3;
	localparam int XC_SVC      = 2;
	localparam int XC_FULL     = 1;
	localparam int XC_EMPTY    = 0;

	// Port control and capability b field positions
	localparam int DC_DIR      = 5;
	localparam int DC_STROBE   = 0;
	localparam int DC_AUTOFD   = 1;
	localparam int DC_INIT     = 2;
	localparam int DC_SELIN    = 3;
	localparam int CB_IRQ      = 6;

	// Fixed values and sizes
	localparam logic [7:0] CAP_A_VAL  = 8'h10; // Eight bit implementation
	localparam int         FIFO_DEPTH = 16;
	localparam int         THR_BITS   = 4;

	// Operating modes
	typedef enum logic [2:0] {
		EPC_M_SPP   = 3'h0,
		EPC_M_BIDIR = 3'h1,
		EPC_M_PFIFO = 3'h2,
		EPC_M_ECP   = 3'h3,
		EPC_M_EPP   = 3'h4,
		EPC_M_RSVD  = 3'h5,
		EPC_M_TEST  = 3'h6,
		EPC_M_CFG   = 3'h7
	} epc_mode_type;

	// Reset values
	localparam epc_mode_type MODE_RST = EPC_M_SPP;
	localparam logic       FLT_RST  = 1'b1;
	localparam logic       DMA_RST  = 1'b0;
	localparam logic       SVC_RST  = 1'b1;
	localparam logic [5:0] DCTL_RST = 6'h00;
	localparam logic [7:0] DATA_RST = 8'h00;

	// Queue entry: command tag plus byte
	typedef struct packed {
		logic       cmd;
		logic [7:0] data;
	} epc_qent_type;

	// Four control lines, all active low on the cable
	typedef struct packed {
		logic host_select_out_n;
		logic init_out_n;
		logic auto_feed_out_n;
		logic strobe_out_n;
	} epc_ctl_type;

endpackage

// *** tb_ecp_extended_mode_control.sv ***
// Purpose: self-checking bench of the extended port control block
// Assumes: classic Wishbone master, peripheral model on the cable side
// Notes:   DMA strobe held idle; queue filled by host writes only, mode 010 never selected
`timescale 1ns/100ps
module tb_ecp_extended_mode_control;
	logic clk = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [12:0] adr = 13'h0000;
	logic [31:0] wd = 32'h0, rdat;
	logic ack, fault = 1'b0, slow = 1'b1, tx_valid, tx_ready, rx_valid;
	logic rx_ready, irq, pd_oe_n, dir_in, epp, pe_n, dma_req;
	logic [3:0] txl = 4'h3, rxl = 4'h1;
	logic tc = 1'b0, cfg4 = 1'b0;
	logic [7:0] pd_i = 8'h00, pd_o, rx_data, dma_rdat, q;
	epc_pkg::epc_qent_type tx_ent;
	epc_pkg::epc_ctl_type eng = 4'hf, ctl_o, ctl_oe_n;
	epc_pkg::epc_mode_type mode;
	int num_errors = 0, compares = 0, irqs = 0, base;
	initial forever #25 clk = ~clk;
	// Count interrupt pulses
	always @(posedge clk) if (irq === 1'b1) irqs <= irqs + 1;
	epc_ctrl DUT (.clk(clk), .arst_n(arst_n), .wb_cyc(cyc), .wb_stb(stb),
		.wb_we(we), .wb_adr(adr), .wb_sel(4'hf), .wb_wdat(wd),
		.wb_rdat(rdat), .wb_ack(ack), .tx_free_level(txl),
		.rx_fill_level(rxl), .chip_config_four(cfg4), .dma_tc(tc),
		.dma_ack(1'b0), .dma_wdat(8'h00), .dma_req(dma_req),
		.dma_rdat(dma_rdat), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_ent(tx_ent), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_data(rx_data), .eng_ctl(eng), .peripheral_error_in_n(pe_n),
		.pd_i(pd_i), .pd_o(pd_o), .pd_oe_n(pd_oe_n), .ctl_o(ctl_o),
		.ctl_oe_n(ctl_oe_n), .mode(mode), .dir_in(dir_in),
		.epp_active(epp), .irq_pulse(irq));
	epc_periph_model P (.clk(clk), .slow(slow), .tx_valid(tx_valid),
		.tx_ent(tx_ent), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .fault_req(fault), .peripheral_error_in_n(pe_n));
	// One classic bus cycle, held until ack is taken
	task wb(input logic w, input logic [10:0] idx, input logic [7:0] d);
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w;
		adr <= {idx, 2'b00}; wd <= {24'h0, d};
		// Wait for the edge that samples ack high; watchdog ends a hang
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat[7:0];
		cyc <= 1'b0; stb <= 1'b0;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		if (num_errors == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task t_reset;
		wb(0, epc_pkg::IDX_XCTL, 0); chk(q, 8'h15);
		wb(1, epc_pkg::IDX_DCTL, 8'h01);
		// Control register lands, then the line flops follow
		repeat (2) @(posedge clk);
		chk({4'h0, ctl_o}, 8'h0a);
		chk({4'h0, ctl_oe_n}, 8'h0a);
		wb(1, epc_pkg::IDX_DCTL, 8'h00);
	endtask
	task t_test;
		base = irqs;
		wb(1, epc_pkg::IDX_XCTL, 8'hd0);
		wb(0, epc_pkg::IDX_XCTL, 0); chk(q, 8'hd5);
		chk(8'(irqs - base), 8'h01);
		for (int i = 0; i < 16; i++) wb(1, epc_pkg::IDX_FIFO, 8'h40 + 8'(i));
		wb(0, epc_pkg::IDX_XCTL, 0); chk(q, 8'hd6);
		wb(0, epc_pkg::IDX_FIFO, 0); chk(q, 8'h40);
		wb(1, epc_pkg::IDX_XCTL, 8'h60);
		@(posedge clk);
		chk({5'h0, mode}, {5'h0, epc_pkg::EPC_M_TEST});
		wb(1, epc_pkg::IDX_XCTL, 8'h14);
		wb(0, epc_pkg::IDX_XCTL, 0); chk(q, 8'h15);
		wb(1, epc_pkg::IDX_XCTL, 8'hf4);
		wb(0, epc_pkg::IDX_FIFO, 0); chk(q, 8'h10);
		wb(1, epc_pkg::IDX_XCTL, 8'h14);
	endtask
	task t_fault;
		base = irqs;
		wb(1, epc_pkg::IDX_DCTL, 8'h00);
		wb(1, epc_pkg::IDX_XCTL, 8'h74);
		fault <= 1'b1;
		repeat (4) @(posedge clk);
		chk(8'(irqs - base), 8'h00);
		wb(1, epc_pkg::IDX_XCTL, 8'h64);
		repeat (3) @(posedge clk);
		chk(8'(irqs - base), 8'h01);
		fault <= 1'b0;
		repeat (2) @(posedge clk);
		fault <= 1'b1;
		repeat (3) @(posedge clk);
		chk(8'(irqs - base), 8'h02);
	endtask
	task t_ecp;
		int n;
		n = 0;
		wb(1, epc_pkg::IDX_DATA, 8'ha5);
		wb(1, epc_pkg::IDX_FIFO, 8'h3c);
		while (P.n_got < 2 && n < 100) begin @(posedge clk); n++; end
		chk({7'h0, P.got[0].cmd}, 8'h01);
		chk(P.got[0].data, 8'ha5);
		chk({7'h0, P.got[1].cmd}, 8'h00);
		chk(P.got[1].data, 8'h3c);
		wb(1, epc_pkg::IDX_XCTL, 8'h14);
	endtask
	// Pin readback, reverse fill threshold, DMA stop and EPP option
	task t_rev;
		pd_i <= 8'h5a;
		wb(1, epc_pkg::IDX_DATA, 8'h96);
		wb(1, epc_pkg::IDX_XCTL, 8'h34);
		chk(pd_o, 8'h96);
		wb(0, epc_pkg::IDX_DATA, 0); chk(q, 8'h5a);
		wb(1, epc_pkg::IDX_DCTL, 8'h20);
		wb(1, epc_pkg::IDX_XCTL, 8'hd4);
		wb(1, epc_pkg::IDX_FIFO, 8'h11);
		wb(1, epc_pkg::IDX_FIFO, 8'h22);
		chk({6'h0, dir_in, pd_oe_n}, 8'h03);
		base = irqs;
		wb(1, epc_pkg::IDX_XCTL, 8'hd0);
		wb(0, epc_pkg::IDX_XCTL, 0); chk(q, 8'hd4);
		chk(8'(irqs - base), 8'h01);
		wb(1, epc_pkg::IDX_XCTL, 8'hd8);
		@(posedge clk);
		chk({7'h0, dma_req}, 8'h01);
		base = irqs;
		tc <= 1'b1;
		@(posedge clk);
		tc <= 1'b0;
		wb(0, epc_pkg::IDX_XCTL, 0); chk(q, 8'hdc);
		chk(8'(irqs - base), 8'h01);
		chk({7'h0, dma_req}, 8'h00);
		wb(1, epc_pkg::IDX_XCTL, 8'h34);
		wb(1, epc_pkg::IDX_DCTL, 8'h00);
		wb(1, epc_pkg::IDX_XCTL, 8'h94);
		@(posedge clk);
		chk({7'h0, epp}, 8'h00);
		cfg4 <= 1'b1;
		@(posedge clk);
		chk({7'h0, epp}, 8'h01);
		cfg4 <= 1'b0;
		wb(1, epc_pkg::IDX_XCTL, 8'h14);
	endtask
	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		tally_and_finish;
	end
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset;
		t_test;
		t_fault;
		t_ecp;
		t_rev;
		tally_and_finish;
	end
endmodule // tb_ecp_extended_mode_control
